// ==== hw_pd_defines.svh ====
// constants for the hardware power-down and wake sequencer
`ifndef HW_PD_DEFINES_SVH
`define HW_PD_DEFINES_SVH
`define HPD_ADDR_W 12
`define HPD_RESET_ADDR 12'h000
`define HPD_VECTOR_ADDR 12'h003
`define HPD_ALE_CNT_W 2
`define HPD_ALE_MIN 2'h2
`define HPD_SYNC_W 3
`endif

// ==== hw_pd_pkg.sv ====
// types shared by the power-down sequencer
`default_nettype none
package hw_pd_pkg;
   typedef enum logic [1:0] {S_RUN, S_DOWN, S_RSTWAIT, S_INTWAIT} pd_state_t;
   typedef enum logic [1:0] {RESUME_NONE, RESUME_RESET, RESUME_VECTOR, RESUME_CONT} resume_kind_t;
endpackage : hw_pd_pkg
`default_nettype wire

// ==== pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`default_nettype none
`include "hw_pd_defines.svh"
module pin_sync #(
   parameter logic RST_VAL = 1'b1
) (
   // clocking
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // pin and result
   input wire logic i_pin,
   output logic o_level
);
   logic [`HPD_SYNC_W-1:0] stage;
   logic [`HPD_SYNC_W-1:0] next_stage;
   logic level;
   logic next_level;

   // shift chain; output follows once stages two and three agree
   always_comb
   begin
      next_stage = {stage[`HPD_SYNC_W-2:0], i_pin};
      next_level = (stage[`HPD_SYNC_W-2] == stage[`HPD_SYNC_W-1]) ? stage[`HPD_SYNC_W-1] : level;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         stage <= {`HPD_SYNC_W{RST_VAL}};
         level <= RST_VAL;
      end
      else if (i_ce)
      begin
         stage <= next_stage;
         level <= next_level;
      end
   end

   assign o_level = level;
endmodule : pin_sync
`default_nettype wire

// ==== hw_powerdown_wake_control.sv ====
// hardware power-down entry and wake path selection
`default_nettype none
`include "hw_pd_defines.svh"
module hw_powerdown_wake_control
   import hw_pd_pkg::*;
(
   // clocking
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // device pins, asynchronous
   input wire logic i_powerdown_ctrl_pin,
   input wire logic i_reset_n_pin,
   input wire logic i_int_n_pin,
   // from CPU core, same clock
   input wire logic i_irq_enable_instr,
   input wire logic i_irq_disable_instr,
   input wire logic i_in_isr,
   input wire logic i_ale_pulse,
   input wire logic i_osc_stable,
   input wire logic i_test0_out_en,
   // to oscillator and CPU
   output logic o_osc_enable,
   output logic o_cpu_run,
   output logic o_cpu_reset,
   output logic o_irq_enable,
   // pin drive permission
   output logic o_pins_drive,
   output logic o_test0_drive,
   // resume decision
   output logic o_resume_valid,
   output resume_kind_t o_resume_kind,
   output logic [`HPD_ADDR_W-1:0] o_resume_addr
);
   logic pd_s;
   logic rst_s;
   logic int_s;
   pd_state_t state;
   pd_state_t next_state;
   logic [`HPD_ALE_CNT_W-1:0] ale_cnt;
   logic [`HPD_ALE_CNT_W-1:0] next_ale_cnt;
   logic irq_en;
   logic next_irq_en;
   logic isr_at_down;
   logic next_isr_at_down;
   logic resume_valid;
   logic next_resume_valid;
   resume_kind_t resume_kind;
   resume_kind_t next_resume_kind;
   logic [`HPD_ADDR_W-1:0] resume_addr;
   logic [`HPD_ADDR_W-1:0] next_resume_addr;

   // pin synchronisers, all pins idle high
   pin_sync #(.RST_VAL(1'b1)) u_pd_sync (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
      .i_pin(i_powerdown_ctrl_pin), .o_level(pd_s));
   pin_sync #(.RST_VAL(1'b1)) u_rst_sync (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
      .i_pin(i_reset_n_pin), .o_level(rst_s));
   pin_sync #(.RST_VAL(1'b1)) u_int_sync (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
      .i_pin(i_int_n_pin), .o_level(int_s));

   // address to resume at for each path
   function automatic logic [`HPD_ADDR_W-1:0] path_addr(input resume_kind_t k);
      path_addr = (k == RESUME_VECTOR) ? `HPD_VECTOR_ADDR : `HPD_RESET_ADDR;
   endfunction : path_addr

   // irq enable flag; disable and cpu reset win over enable
   always_comb
   begin
      next_irq_en = irq_en;
      if (i_irq_enable_instr)
      begin
         next_irq_en = 1'b1;
      end
      if (i_irq_disable_instr)
      begin
         next_irq_en = 1'b0;
      end
      // a reset-pin wake is a hardware reset of the cpu
      if (state == S_RSTWAIT)
      begin
         next_irq_en = 1'b0;
      end
   end

   // sequencer: entry, wake sampling, path choice
   always_comb
   begin
      next_state = state;
      next_ale_cnt = ale_cnt;
      next_isr_at_down = isr_at_down;
      next_resume_valid = 1'b0;
      next_resume_kind = resume_kind;
      next_resume_addr = resume_addr;
      unique case (state)
         S_RUN:
         begin
            if (!pd_s)
            begin
               next_state = S_DOWN;
               next_isr_at_down = i_in_isr;
            end
         end
         S_DOWN:
         begin
            next_ale_cnt = '0;
            if (pd_s)
            begin
               // reset has priority over interrupt, one path only
               if (!rst_s)
               begin
                  next_state = S_RSTWAIT;
               end
               else if (!int_s)
               begin
                  next_state = S_INTWAIT;
               end
               else
               begin
                  next_state = S_RUN;
                  next_resume_valid = 1'b1;
                  next_resume_kind = RESUME_CONT;
               end
            end
         end
         S_RSTWAIT:
         begin
            // cpu held in reset until the pin releases on a stable clock
            if (rst_s && i_osc_stable)
            begin
               next_state = S_RUN;
               next_resume_valid = 1'b1;
               next_resume_kind = RESUME_RESET;
               next_resume_addr = path_addr(RESUME_RESET);
            end
         end
         S_INTWAIT:
         begin
            if (!int_s && i_ale_pulse)
            begin
               next_ale_cnt = ale_cnt + 1'b1;
            end
            if (!int_s && i_ale_pulse && (ale_cnt + 1'b1) >= `HPD_ALE_MIN)
            begin
               next_state = S_RUN;
               next_resume_valid = 1'b1;
               if (irq_en && !isr_at_down)
               begin
                  next_resume_kind = RESUME_VECTOR;
                  next_resume_addr = path_addr(RESUME_VECTOR);
               end
               else
               begin
                  next_resume_kind = RESUME_CONT;
               end
            end
            else if (int_s)
            begin
               // interrupt released early: treat as plain wake
               next_state = S_RUN;
               next_resume_valid = 1'b1;
               next_resume_kind = RESUME_CONT;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= S_RUN;
         ale_cnt <= '0;
         irq_en <= 1'b0;
         isr_at_down <= 1'b0;
         resume_valid <= 1'b0;
         resume_kind <= RESUME_NONE;
         resume_addr <= `HPD_RESET_ADDR;
      end
      else if (i_ce)
      begin
         state <= next_state;
         ale_cnt <= next_ale_cnt;
         irq_en <= next_irq_en;
         isr_at_down <= next_isr_at_down;
         resume_valid <= next_resume_valid;
         resume_kind <= next_resume_kind;
         resume_addr <= next_resume_addr;
      end
   end

   // control outputs decoded from state; test0 also gated by its enable, irq enable and resume from registers
   assign o_osc_enable = (state != S_DOWN);
   assign o_cpu_run = (state == S_RUN) || (state == S_INTWAIT);
   assign o_cpu_reset = (state == S_RSTWAIT);
   assign o_pins_drive = (state != S_DOWN);
   assign o_test0_drive = i_test0_out_en && (state != S_DOWN);
   assign o_irq_enable = irq_en;
   assign o_resume_valid = resume_valid;
   assign o_resume_kind = resume_kind;
   assign o_resume_addr = resume_addr;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_plain_exit;
      i_ce && state == S_DOWN && pd_s && rst_s && int_s;
   endsequence
   sequence s_down_entry;
      i_ce && state == S_RUN && !pd_s;
   endsequence

   a_down_stops_osc: assert property (s_down_entry |=> !o_osc_enable && !o_cpu_run)
      else $error("oscillator not stopped on power-down");
   a_down_pins_float: assert property (state == S_DOWN |-> !o_pins_drive)
      else $error("pins driven during power-down");
   a_reset_wake_addr: assert property (o_resume_valid && o_resume_kind == RESUME_RESET
      |-> o_resume_addr == `HPD_RESET_ADDR && $past(state) == S_RSTWAIT)
      else $error("reset wake not at address zero");
   a_vector_wake: assert property (o_resume_valid && o_resume_kind == RESUME_VECTOR
      |-> o_resume_addr == `HPD_VECTOR_ADDR && $past(irq_en) && $past(ale_cnt) == 2'h1)
      else $error("vector wake wrong");
   a_isr_no_vector: assert property (o_resume_valid && isr_at_down
      |-> o_resume_kind != RESUME_VECTOR)
      else $error("vectored again from inside isr");
   a_disabled_cont: assert property (o_resume_valid && !$past(irq_en)
      |-> o_resume_kind != RESUME_VECTOR)
      else $error("vector taken with irq disabled");
   a_disable_clears: assert property (i_ce && i_irq_disable_instr |=> !o_irq_enable)
      else $error("irq enable not cleared");
   a_reset_clears_irq: assert property (i_ce && o_cpu_reset |=> !o_irq_enable)
      else $error("irq enable kept through cpu reset");
   a_enable_sets: assert property (i_ce && i_irq_enable_instr && !i_irq_disable_instr
      |=> o_irq_enable)
      else $error("irq enable not set");
   a_plain_resume: assert property (s_plain_exit
      |=> o_resume_valid && o_resume_kind == RESUME_CONT && state == S_RUN)
      else $error("plain wake did not continue");
   a_test0_float: assert property (state == S_DOWN |-> !o_test0_drive)
      else $error("test0 driven during power-down");
   a_one_path: assert property (o_resume_valid |-> $past(state) != S_RUN
      && o_resume_kind != RESUME_NONE)
      else $error("resume without a single chosen path");
endmodule : hw_powerdown_wake_control
`default_nettype wire

// ==== pd_system_model.sv ====
// far-side model: system logic on power-down, reset and interrupt pins
`default_nettype none
module pd_system_model (
   // clocking
   input wire logic i_clk,
   // from the device
   input wire logic i_osc_enable,
   input wire logic i_cpu_run,
   // pins and core strobes
   output logic o_pd,
   output logic o_rst_n,
   output logic o_int_n,
   output logic o_ale,
   output logic o_osc_stable
);
   timeunit 1ns;
   timeprecision 1ps;
   int osc_cnt = 0;
   int ale_cnt = 0;
   initial {o_pd, o_rst_n, o_int_n} = 3'b111;
   // oscillator settles six cycles after enable; strobe every third running cycle
   always @(posedge i_clk)
   begin
      osc_cnt <= i_osc_enable ? ((osc_cnt < 6) ? osc_cnt + 1 : 6) : 0;
      ale_cnt <= i_cpu_run ? (ale_cnt + 1) % 3 : 0;
   end
   assign o_osc_stable = (osc_cnt == 6);
   assign o_ale = i_cpu_run && (ale_cnt == 2);
   // pull the power-down pin low
   task sleep();
      @(posedge i_clk) #1 o_pd = 1'b0;
   endtask : sleep
   // raise power-down with chosen reset and interrupt levels
   task wake(input logic rst_lv, input logic int_lv);
      @(posedge i_clk) #1 {o_rst_n, o_int_n} = {rst_lv, int_lv};
      repeat (4) @(posedge i_clk);
      #1 o_pd = 1'b1;
      // reset held low until oscillator settles
      repeat (60) @(posedge i_clk) if (o_osc_stable) break;
      // interrupt held well past two strobes
      repeat (20) @(posedge i_clk);
      #1 {o_rst_n, o_int_n} = 2'b11;
   endtask : wake
   // wake by an interrupt that lets go before any strobe is seen
   task wake_short();
      @(posedge i_clk) #1 o_int_n = 1'b0;
      repeat (4) @(posedge i_clk);
      #1 o_pd = 1'b1;
      repeat (2) @(posedge i_clk);
      #1 o_int_n = 1'b1;
      repeat (20) @(posedge i_clk);
   endtask : wake_short
endmodule : pd_system_model
`default_nettype wire

// ==== hw_powerdown_wake_control_bench.sv ====
// self-checking bench for the power-down and wake sequencer
`default_nettype none
`include "hw_pd_defines.svh"
module hw_powerdown_wake_control_bench
   import hw_pd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, ce = 1, en_i = 0, dis_i = 0, isr = 0, t0en = 0;
   wire logic pd, rst_n, int_n, ale, osc_st;
   logic osc_en, run, cpu_rst, irq_en, pins, t0drv, rv;
   resume_kind_t kind;
   logic [11:0] addr;
   int n_fail = 0, compares = 0, n_seen = 0, rst_cyc = 0;
   hw_powerdown_wake_control u_hw_powerdown_wake_control (.i_clk(clk), .i_rst(rst),
      .i_ce(ce), .i_powerdown_ctrl_pin(pd), .i_reset_n_pin(rst_n), .i_int_n_pin(int_n),
      .i_irq_enable_instr(en_i), .i_irq_disable_instr(dis_i), .i_in_isr(isr),
      .i_ale_pulse(ale), .i_osc_stable(osc_st), .i_test0_out_en(t0en),
      .o_osc_enable(osc_en), .o_cpu_run(run), .o_cpu_reset(cpu_rst), .o_irq_enable(irq_en),
      .o_pins_drive(pins), .o_test0_drive(t0drv), .o_resume_valid(rv),
      .o_resume_kind(kind), .o_resume_addr(addr));
   pd_system_model u_pd_system_model (.i_clk(clk), .i_osc_enable(osc_en), .i_cpu_run(run),
      .o_pd(pd), .o_rst_n(rst_n), .o_int_n(int_n), .o_ale(ale), .o_osc_stable(osc_st));
   initial forever #5 clk = ~clk;
   // count resume pulses and reset cycles where outputs are settled
   always @(negedge clk)
   begin
      if (rv === 1'b1) n_seen++;
      if (cpu_rst === 1'b1) rst_cyc++;
   end
   task close_out();
      if (n_fail == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   task chk_bit(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask : chk_bit
   task chk_word(input string what, input logic [11:0] exp, input logic [11:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk_word
   // one-cycle instruction pulses
   task pulse(input logic e, input logic d);
      @(posedge clk) #1 {en_i, dis_i} = {e, d};
      @(posedge clk) #1 {en_i, dis_i} = 2'b00;
   endtask : pulse
   // enter power-down and check the stopped state
   task go_down(input logic t0);
      t0en = t0;
      u_pd_system_model.sleep();
      repeat (8) @(posedge clk);
      #1 chk_bit("osc enable", 1'b0, osc_en);
      chk_bit("cpu run", 1'b0, run);
      chk_bit("pins drive", 1'b0, pins);
      chk_bit("test0 drive", 1'b0, t0drv);
   endtask : go_down
   // wake with pin levels and check the single resume decision
   task wake_chk(input logic r, input logic i, input resume_kind_t k, input logic [11:0] a);
      n_seen = 0;
      rst_cyc = 0;
      u_pd_system_model.wake(r, i);
      repeat (10) @(posedge clk);
      #1 chk_word("resume count", 12'h001, 12'(n_seen));
      chk_word("resume kind", 12'(k), 12'(kind));
      chk_word("resume addr", a, addr);
      chk_bit("cpu reset seen", !r, rst_cyc > 0);
      chk_bit("osc running", 1'b1, osc_en & run & pins & ~cpu_rst);
      chk_bit("test0 drive", t0en, t0drv);
   endtask : wake_chk
   task t_reset_state();
      chk_bit("irq enable", 1'b0, irq_en);
      chk_word("resume kind", 12'(RESUME_NONE), 12'(kind));
      pulse(1'b1, 1'b0);
      chk_bit("irq enable", 1'b1, irq_en);
      pulse(1'b1, 1'b1);
      chk_bit("irq enable", 1'b0, irq_en);
   endtask : t_reset_state
   task t_vector();
      pulse(1'b1, 1'b0);
      go_down(1'b0);
      wake_chk(1'b1, 1'b0, RESUME_VECTOR, `HPD_VECTOR_ADDR);
   endtask : t_vector
   task t_reset_wins();
      go_down(1'b1);
      wake_chk(1'b0, 1'b0, RESUME_RESET, `HPD_RESET_ADDR);
      chk_bit("irq enable", 1'b0, irq_en);
   endtask : t_reset_wins
   task t_plain();
      pulse(1'b1, 1'b0);
      go_down(1'b1);
      wake_chk(1'b1, 1'b1, RESUME_CONT, `HPD_RESET_ADDR);
   endtask : t_plain
   task t_isr();
      isr = 1'b1;
      go_down(1'b0);
      isr = 1'b0;
      wake_chk(1'b1, 1'b0, RESUME_CONT, `HPD_RESET_ADDR);
   endtask : t_isr
   task t_disabled();
      pulse(1'b0, 1'b1);
      go_down(1'b0);
      wake_chk(1'b1, 1'b0, RESUME_CONT, `HPD_RESET_ADDR);
   endtask : t_disabled
   // interrupt let go before two strobes: plain continue though enabled
   task t_early();
      pulse(1'b1, 1'b0);
      go_down(1'b0);
      n_seen = 0;
      u_pd_system_model.wake_short();
      #1 chk_word("resume count", 12'h001, 12'(n_seen));
      chk_word("resume kind", 12'(RESUME_CONT), 12'(kind));
      chk_bit("irq enable", 1'b1, irq_en);
   endtask : t_early
   // clock enable low freezes the enable flag against instructions
   task t_freeze();
      ce = 1'b0;
      pulse(1'b0, 1'b1);
      chk_bit("irq enable frozen", 1'b1, irq_en);
      ce = 1'b1;
      pulse(1'b0, 1'b1);
      chk_bit("irq enable", 1'b0, irq_en);
   endtask : t_freeze
   // watchdog on the whole run
   initial
   begin
      #100us;
      n_fail++;
      close_out();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      t_reset_state();
      t_vector();
      t_reset_wins();
      t_plain();
      t_isr();
      t_disabled();
      t_early();
      t_freeze();
      close_out();
   end
endmodule : hw_powerdown_wake_control_bench
`default_nettype wire
